// [verilog/pcms_regs.svh]
/*
  Register offsets, field positions, reset values and strap codes for the
  clock mode select block. Assumes inclusion by bare name from the design.
*/
`ifndef PCMS_REGS_SVH
`define PCMS_REGS_SVH

// data address of the clock generator config register
`define PCMS_CFG_ADDR 16'h0058

// field positions of clock_generator_config
`define PCMS_MUL_HI 15
`define PCMS_MUL_LO 12
`define PCMS_DIV_BIT 11
`define PCMS_CNT_HI 10
`define PCMS_CNT_LO 3
`define PCMS_ON_BIT 2
`define PCMS_NDIV_BIT 1
`define PCMS_STAT_BIT 0

// strap codes {pin_a, pin_b, pin_c}
`define PCMS_STRAP_000 3'h0
`define PCMS_STRAP_001 3'h1
`define PCMS_STRAP_010 3'h2
`define PCMS_STRAP_STOP 3'h3
`define PCMS_STRAP_OSC 3'h4
`define PCMS_STRAP_PLL1 3'h5
`define PCMS_STRAP_110 3'h6
`define PCMS_STRAP_RSVD 3'h7

// config reset values per strap code
`define PCMS_RST_000 16'h0000
`define PCMS_RST_001 16'h1000
`define PCMS_RST_010 16'h2000
`define PCMS_RST_STOP 16'h0000
`define PCMS_RST_OSC 16'h4000
`define PCMS_RST_PLL1 16'h0007
`define PCMS_RST_110 16'h6000
`define PCMS_RST_RSVD 16'h7000

// sync cycles before straps are taken
`define PCMS_STRAP_WAIT 2'h2

`endif

// [verilog/pcms_pkg.sv]
/*
  Types of the clock mode select block: loop state and the state struct.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package pcms_pkg;

  // loop state, gray along off -> acquire -> locked
  typedef enum logic [1:0] {
    PCMS_OFF = 2'h0,
    PCMS_ACQ = 2'h1,
    PCMS_LOCK = 2'h3
  } pcms_loop_t;

  // whole block state
  typedef struct packed {
    logic [15:0] cfg;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [1:0] init_cnt;
    logic done;
    pcms_loop_t loop;
    logic locked;
    logic [11:0] timer;
    logic sel;
    logic div4;
    logic [1:0] dcnt;
    logic div_clk;
    logic [4:0] ratio;
    logic pll_en;
    logic osc_en;
    logic stop;
    logic [15:0] rdata;
  } pcms_state_t;

endpackage

`default_nettype wire

// [verilog/pcms_clock_mode_select.sv]
/*
  Clock mode select: config register, strap reset load, loop state,
  lock timer, divider clock and glitch-free source select.
  Assumes a single-cycle on-chip data bus on the reference clock and
  strap pins that are asynchronous to it.
*/
`include "pcms_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module pcms_clock_mode_select #(
  parameter int LOCK_SCALE = 16 // cycles per lock count step
) (
  input wire logic i_clk, // reference clock
  input wire logic i_arst_n, // async reset, active low
  input wire logic i_ce, // clock enable, freezes state when low
  input wire logic i_clock_strap_pin_a, // strap, code msb
  input wire logic i_clock_strap_pin_b, // strap, middle bit
  input wire logic i_clock_strap_pin_c, // strap, code lsb
  input wire logic [15:0] i_mem_addr, // data address
  input wire logic i_mem_wr, // write strobe
  input wire logic i_mem_rd, // read strobe
  input wire logic [15:0] i_mem_wdata, // write data
  output logic [15:0] o_mem_rdata, // read data, next cycle
  output logic o_div_clk, // divided master clock
  output logic o_mclk_sel, // 1 multiplied source, 0 divider
  output logic [4:0] o_pll_ratio, // multiplier ratio 1..31
  output logic o_pll_enable, // loop powered
  output logic o_pll_locked, // loop past acquisition
  output logic o_crystal_drive_pin_en, // internal oscillator on
  output logic o_clock_stop // stop mode strap
);

  // refuse lock scales that overflow the 12-bit timer
  if (LOCK_SCALE < 1 || LOCK_SCALE > 16) begin : g_bad_scale
    $error("LOCK_SCALE must be 1 to 16");
  end

  ////////////////////////////////////////////////////////////////////
  // decode helpers

  // ratio code {div, mul} maps to ratio code+1, top code clamps
  function automatic logic [4:0] f_ratio(input logic [15:0] cfg);
    logic [4:0] code;
    code = {cfg[`PCMS_DIV_BIT], cfg[`PCMS_MUL_HI:`PCMS_MUL_LO]};
    f_ratio = (code == 5'h1F) ? 5'h1F : code + 5'h01;
  endfunction

  // strap code to config reset value
  function automatic logic [15:0] f_strap_cfg(input logic [2:0] code);
    case (code)
      `PCMS_STRAP_000: f_strap_cfg = `PCMS_RST_000;
      `PCMS_STRAP_001: f_strap_cfg = `PCMS_RST_001;
      `PCMS_STRAP_010: f_strap_cfg = `PCMS_RST_010;
      `PCMS_STRAP_STOP: f_strap_cfg = `PCMS_RST_STOP;
      `PCMS_STRAP_OSC: f_strap_cfg = `PCMS_RST_OSC;
      `PCMS_STRAP_PLL1: f_strap_cfg = `PCMS_RST_PLL1;
      `PCMS_STRAP_110: f_strap_cfg = `PCMS_RST_110;
      default: f_strap_cfg = `PCMS_RST_RSVD;
    endcase
  endfunction

  // lock timer load from the count field
  function automatic logic [11:0] f_lock(input logic [15:0] cfg);
    f_lock = 12'(int'(cfg[`PCMS_CNT_HI:`PCMS_CNT_LO]) * LOCK_SCALE);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // state

  pcms_pkg::pcms_state_t st_reg;
  pcms_pkg::pcms_state_t st_next;
  logic wr_hit;
  logic rd_hit;
  logic [15:0] wcfg;

  // bus decode
  assign wr_hit = i_mem_wr && (i_mem_addr == `PCMS_CFG_ADDR);
  assign rd_hit = i_mem_rd && (i_mem_addr == `PCMS_CFG_ADDR);
  assign wcfg = {i_mem_wdata[15:1], 1'b0};

  // next-state logic
  always_comb begin
    st_next = st_reg;
    if (i_ce) begin
      // strap synchroniser
      st_next.sync1 = {i_clock_strap_pin_a, i_clock_strap_pin_b, i_clock_strap_pin_c};
      st_next.sync2 = st_reg.sync1;
      // lock timer counts down
      if (st_reg.timer != 12'h000) begin
        st_next.timer = st_reg.timer - 12'h001;
      end
      // loop state
      case (st_reg.loop)
        pcms_pkg::PCMS_OFF: begin
          if (st_reg.done && st_reg.cfg[`PCMS_ON_BIT]) begin
            st_next.loop = pcms_pkg::PCMS_ACQ;
          end
        end
        pcms_pkg::PCMS_ACQ: begin
          if (!st_reg.cfg[`PCMS_ON_BIT] && st_reg.timer == 12'h000) begin
            st_next.loop = pcms_pkg::PCMS_OFF;
          end else if (st_reg.timer == 12'h000) begin
            st_next.loop = pcms_pkg::PCMS_LOCK;
          end
        end
        pcms_pkg::PCMS_LOCK: begin
          if (!st_reg.cfg[`PCMS_ON_BIT] && st_reg.timer == 12'h000) begin
            st_next.loop = pcms_pkg::PCMS_OFF;
          end
        end
        default: st_next.loop = pcms_pkg::PCMS_OFF;
      endcase
      // strap load after release, then software writes
      if (!st_reg.done) begin
        if (st_reg.init_cnt == `PCMS_STRAP_WAIT) begin
          st_next.done = 1'b1;
          st_next.cfg = f_strap_cfg(st_reg.sync2);
          st_next.osc_en = (st_reg.sync2 == `PCMS_STRAP_OSC);
          st_next.stop = (st_reg.sync2 == `PCMS_STRAP_STOP);
          st_next.timer = f_lock(f_strap_cfg(st_reg.sync2));
        end else begin
          st_next.init_cnt = st_reg.init_cnt + 2'h1;
        end
      end else if (wr_hit) begin
        st_next.cfg = wcfg;
        if (wcfg[15:1] != st_reg.cfg[15:1]) begin
          st_next.timer = f_lock(wcfg);
        end
        // new ratio forces reacquisition
        if (st_reg.loop != pcms_pkg::PCMS_OFF && f_ratio(wcfg) != f_ratio(st_reg.cfg)) begin
          st_next.loop = pcms_pkg::PCMS_ACQ;
        end
      end
      st_next.ratio = f_ratio(st_next.cfg);
      st_next.pll_en = (st_next.loop != pcms_pkg::PCMS_OFF);
      st_next.locked = (st_next.loop == pcms_pkg::PCMS_LOCK);
      // multiplied source only when locked and timer expired
      if (st_reg.loop != pcms_pkg::PCMS_LOCK) begin
        st_next.sel = 1'b0;
      end else if (st_reg.timer == 12'h000) begin
        st_next.sel = st_reg.cfg[`PCMS_NDIV_BIT] && st_reg.cfg[`PCMS_ON_BIT];
      end
      // divider, ratio change only at wrap so no short phase
      if (!st_reg.stop) begin
        st_next.dcnt = st_reg.dcnt + 2'h1;
        if (st_next.dcnt == 2'h0) begin
          st_next.div4 = st_reg.cfg[`PCMS_DIV_BIT];
        end
        st_next.div_clk = st_reg.div4 ? st_next.dcnt[1] : st_next.dcnt[0];
      end
      // read port, unmapped reads as zero
      st_next.rdata = rd_hit ? {st_reg.cfg[15:1], st_reg.sel} : 16'h0000;
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign o_mem_rdata = st_reg.rdata;
  assign o_div_clk = st_reg.div_clk;
  assign o_mclk_sel = st_reg.sel;
  assign o_pll_ratio = st_reg.ratio;
  assign o_pll_enable = st_reg.pll_en;
  assign o_pll_locked = st_reg.locked;
  assign o_crystal_drive_pin_en = st_reg.osc_en;
  assign o_clock_stop = st_reg.stop;

  ////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // mode bit as a plain net for sampled-value use
  logic ndiv_now;
  assign ndiv_now = st_reg.cfg[`PCMS_NDIV_BIT];

  // strap load event
  sequence s_load(logic [2:0] c);
    i_ce && !st_reg.done && st_reg.init_cnt == `PCMS_STRAP_WAIT && st_reg.sync2 == c;
  endsequence

  // divide by 2 toggles every enabled cycle unless stopped; cycles with dcnt at 3 are not checked
  property p_div2;
    (i_ce && !st_reg.stop && !st_reg.div4 && st_reg.dcnt != 2'h3)
      |=> o_div_clk != $past(o_div_clk);
  endproperty
  a_div2: assert property (p_div2) else $error("div2 clock not toggling");

  // ratio follows config field
  property p_ratio;
    (i_ce && !wr_hit && st_reg.done)
      |=> o_pll_ratio == f_ratio(st_reg.cfg) && o_pll_ratio != 5'h00;
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio mismatch");

  // multiplied source implies loop powered; it only rises with the mode bit set
  property p_sel_pll;
    o_mclk_sel |-> o_pll_enable && ($past(o_mclk_sel) || $past(ndiv_now));
  endproperty
  a_sel_pll: assert property (p_sel_pll) else $error("select without loop");

  // multiplied source only from locked state
  property p_sel_lock;
    $rose(o_mclk_sel) |-> $past(st_reg.loop) == pcms_pkg::PCMS_LOCK;
  endproperty
  a_sel_lock: assert property (p_sel_lock) else $error("select before lock");

  // no switch to multiplied source while timer runs
  property p_timer_hold;
    (st_reg.timer != 12'h000 && !o_mclk_sel) |=> !o_mclk_sel;
  endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("switch before timer");

  // write at config address is stored
  property p_write;
    (i_ce && wr_hit && st_reg.done) |=> st_reg.cfg == ($past(i_mem_wdata) & 16'hFFFE);
  endproperty
  a_write: assert property (p_write) else $error("config write lost");

  // stop strap raises stop output
  property p_stop;
    s_load(`PCMS_STRAP_STOP) |=> o_clock_stop && st_reg.cfg == `PCMS_RST_STOP;
  endproperty
  a_stop: assert property (p_stop) else $error("stop strap ignored");

  // strap 001 loads 1000h without oscillator
  property p_strap_ext;
    s_load(`PCMS_STRAP_001) |=> st_reg.cfg == `PCMS_RST_001 && !o_crystal_drive_pin_en;
  endproperty
  a_strap_ext: assert property (p_strap_ext) else $error("strap 001 value");

  // strap 100 loads 4000h with oscillator
  property p_strap_osc;
    s_load(`PCMS_STRAP_OSC) |=> st_reg.cfg == `PCMS_RST_OSC && o_crystal_drive_pin_en;
  endproperty
  a_strap_osc: assert property (p_strap_osc) else $error("strap 100 value");

  // strap 101 reaches multiplier x1 within a few cycles
  property p_strap_pll;
    s_load(`PCMS_STRAP_PLL1) ##1 i_ce[*4] |-> o_mclk_sel && o_pll_ratio == 5'h01;
  endproperty
  a_strap_pll: assert property (p_strap_pll) else $error("strap 101 mode");

endmodule // pcms_clock_mode_select

`default_nettype wire

// [sim/pcms_clock_mode_select_tb.sv]
/*
  Self-checking bench for the clock mode select block: strap reset load,
  register access, divider rate, multiplier lock and source select.
  Assumes the design files compiled before it and a 100 MHz reference.
*/
`timescale 1ns/1ps
`default_nettype none

module pcms_clock_mode_select_tb;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_ce = 1'b1;
  logic [2:0] strap = 3'h0;
  logic [15:0] i_mem_addr = 16'h0000;
  logic i_mem_wr = 1'b0;
  logic i_mem_rd = 1'b0;
  logic [15:0] i_mem_wdata = 16'h0000;
  logic [15:0] o_mem_rdata;
  logic o_div_clk, o_mclk_sel, o_pll_enable, o_pll_locked, o_osc, o_clock_stop;
  logic [4:0] o_pll_ratio;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  integer seed = 32'h7497;
  // expected config per strap code {a,b,c}
  logic [15:0] rst_tab [8] = '{16'h0000, 16'h1000, 16'h2000, 16'h0000,
                               16'h4000, 16'h0007, 16'h6000, 16'h7000};

  ////////////////////////////////////////////////////////////////////////
  pcms_clock_mode_select #(.LOCK_SCALE(1)) dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
    .i_clock_strap_pin_a(strap[2]), .i_clock_strap_pin_b(strap[1]),
    .i_clock_strap_pin_c(strap[0]), .i_mem_addr(i_mem_addr),
    .i_mem_wr(i_mem_wr), .i_mem_rd(i_mem_rd), .i_mem_wdata(i_mem_wdata),
    .o_mem_rdata(o_mem_rdata), .o_div_clk(o_div_clk), .o_mclk_sel(o_mclk_sel),
    .o_pll_ratio(o_pll_ratio), .o_pll_enable(o_pll_enable),
    .o_pll_locked(o_pll_locked), .o_crystal_drive_pin_en(o_osc),
    .o_clock_stop(o_clock_stop)
  );

  // reference clock, 10 ns period
  always #5 i_clk = ~i_clk;

  // hang guard
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one comparison, counted
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // wait n edges, then settle 1 ns past the last edge
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // one write strobe, taken at the second edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_mem_addr <= a;
    i_mem_wdata <= d;
    i_mem_wr <= 1'b1;
    @(posedge i_clk);
    i_mem_wr <= 1'b0;
  endtask

  // one read strobe, data seen just after the taking edge
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_mem_addr <= a;
    i_mem_rd <= 1'b1;
    @(posedge i_clk);
    i_mem_rd <= 1'b0;
    #1 d = o_mem_rdata;
  endtask

  // reset for 16 cycles with a strap code applied
  task automatic do_reset(input logic [2:0] s);
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    strap <= s;
    repeat (16) @(posedge i_clk);
    i_arst_n <= 1'b1;
    wait_cyc(8);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [15:0] v;
    logic [15:0] w;
    logic [4:0] k;
    logic [7:0] c;
    logic prev;
    int tg;
    int n;
    int codes [5];
    codes = '{0, 14, 29, 30, 31};
    // every strap code
    for (int s = 0; s < 8; s++) begin
      do_reset(3'(s));
      rd(16'h0058, v);
      chk("cfg reset", rst_tab[s], v);
      chk("osc on", {15'h0, s == 4}, {15'h0, o_osc});
      chk("stop", {15'h0, s == 3}, {15'h0, o_clock_stop});
      if (s == 5) begin
        chk("ratio one", 16'h0001, {11'h0, o_pll_ratio});
        chk("mul sel", 16'h0001, {15'h0, o_mclk_sel});
      end
    end
    do_reset(3'h0);
    // divider mode, random fields, loop off
    for (int i = 0; i < 6; i++) begin
      w = 16'($random(seed)) & 16'hFFF9;
      w[11] = i[0]; // alternate divide by 2 and by 4
      wr(16'h0058, w);
      wait_cyc(int'(w[10:3]) + 4);
      rd(16'h0058, v);
      chk("cfg rw", {w[15:1], 1'b0}, v);
      chk("loop off", 16'h0000, {15'h0, o_pll_enable});
      prev = o_div_clk;
      tg = 0;
      repeat (16) begin
        wait_cyc(1);
        if (o_div_clk !== prev) tg++;
        prev = o_div_clk;
      end
      chk("div toggles", w[11] ? 16'd8 : 16'd16, 16'(tg));
    end
    // unmapped and disabled writes are dropped
    wr(16'h0059, 16'hFFFE);
    rd(16'h0059, v);
    chk("unmapped", 16'h0000, v);
    @(posedge i_clk);
    i_ce <= 1'b0;
    wr(16'h0058, ~w);
    i_ce <= 1'b1;
    rd(16'h0058, v);
    chk("cfg kept", {w[15:1], 1'b0}, v);
    // multiplier ratios with lock delay
    foreach (codes[j]) begin
      k = 5'(codes[j]);
      c = 8'($random(seed)) & 8'h0F;
      wr(16'h0058, 16'h0000);
      wait_cyc(24);
      w = {k[3:0], k[4], c, 3'b110};
      wr(16'h0058, w);
      wait_cyc(1);
      chk("sel early", 16'h0000, {15'h0, o_mclk_sel});
      n = 1;
      while (o_mclk_sel !== 1'b1 && n < int'(c) + 12) begin
        wait_cyc(1);
        n++;
      end
      chk("lock wait", 16'h0001, {15'h0, n >= int'(c)});
      chk("sel", 16'h0001, {15'h0, o_mclk_sel});
      chk("locked", 16'h0001, {15'h0, o_pll_locked});
      chk("loop on", 16'h0001, {15'h0, o_pll_enable});
      chk("ratio", (k == 5'd31) ? 16'd31 : 16'(k) + 16'd1, {11'h0, o_pll_ratio});
      rd(16'h0058, v);
      chk("cfg mul", {w[15:1], 1'b1}, v);
    end
    // back to divider, loop powered down
    wr(16'h0058, 16'h0000);
    wait_cyc(24);
    chk("sel off", 16'h0000, {15'h0, o_mclk_sel});
    chk("pll down", 16'h0000, {15'h0, o_pll_enable});
    final_report();
  end
endmodule // pcms_clock_mode_select_tb

`default_nettype wire
